// file: rar_defs.vh
// Constants for the two-wire remote access router.
`ifndef RAR_DEFS_VH
`define RAR_DEFS_VH
`define RAR_CLK_MHZ 125
`define RAR_READY_US 2500
`define RAR_READY_CYC (`RAR_READY_US * `RAR_CLK_MHZ)
`define RAR_PRIM_HI 5'h0_01A
`define RAR_BUS_HI 5'h0_01B
`define RAR_I2C_NODESEL 8'h0_001
`define RAR_SW_NODESEL 4'h0
`define RAR_SW_STATUS 4'h1
`define RAR_SW_LINKDATA 4'h2
`define RAR_NODESEL_RST 8'h0_000
`define RAR_NODE_LSB 0
`define RAR_NODE_MSB 3
`define RAR_PERIPH_BIT 5
`define RAR_BCAST_BIT 7
`define RAR_BYTE_BITS 4'h8
`endif

// file: rar_sync.v
// Two-flop synchroniser, one stage pair per bit.
`timescale 1ns/100ps
module rar_sync #(
    parameter W = 1
) (
    clk,
    rst,
    din,
    dout
);
    input wire clk;
    input wire rst;
    input wire [W-1:0] din;
    output wire [W-1:0] dout;
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg meta_q;
            reg sync_q;
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= din[i];
                    sync_q <= meta_q;
                end
            end
            assign dout[i] = sync_q;
        end
    endgenerate
endmodule

// file: rar_router.v
// Two-wire slave front end that routes register accesses locally or over the audio link.
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`include "rar_defs.vh"
module rar_router #(
    parameter READY_CYC = `RAR_READY_CYC
) (
    input wire clk,
    input wire rst,
    input wire sclIn,
    output reg sclOut,
    output reg sclOeN,
    input wire sdaIn,
    output reg sdaOut,
    output reg sdaOeN,
    input wire masterMode,
    input wire [1:0] addrStrap,
    output reg ready,
    output reg [7:0] regAddr,
    output reg [7:0] regWdata,
    output reg regWr,
    output reg regRd,
    input wire [7:0] regRdata,
    input wire [3:0] swAddr,
    input wire [7:0] swWdata,
    input wire swWr,
    input wire swRd,
    output reg [7:0] swRdata,
    input wire linkClk,
    output reg linkReq,
    output reg linkWrite,
    output reg [3:0] linkNode,
    output reg linkPeriph,
    output reg linkBcast,
    output reg [7:0] linkAddr,
    output reg [7:0] linkWdata,
    input wire linkAck,
    input wire [7:0] linkRdata
);
    localparam ST_IDLE = 4'd0;
    localparam ST_ADDR = 4'd1;
    localparam ST_ACKA = 4'd2;
    localparam ST_RX = 4'd3;
    localparam ST_ACKW = 4'd4;
    localparam ST_FETCH = 4'd5;
    localparam ST_TX = 4'd6;
    localparam ST_MACK = 4'd7;
    localparam ST_LINKW = 4'd8;
    localparam ST_IGN = 4'd9;

    wire [4:0] syncOut;
    wire sclS = syncOut[0];
    wire sdaS = syncOut[1];
    wire lclkS = syncOut[2];
    wire ackS = syncOut[3];
    wire mstS = syncOut[4];

    rar_sync #(.W(5)) uSync (
        .clk(clk),
        .rst(rst),
        .din({masterMode, linkAck, linkClk, sdaIn, sclIn}),
        .dout(syncOut)
    );

    reg sclP_q, sdaP_q, lclkP_q;
    reg [3:0] state_q;
    reg [3:0] cnt_q;
    reg [7:0] shift_q;
    reg gotReg_q, read_q, remote_q, nack_q;
    reg fetchPh_q, issued_q, linkDone_q;
    reg dataAck_q;
    reg [7:0] linkData_q;
    reg [7:0] nodeSel_q;
    reg [1:0] strap_q;
    reg strapDone_q;
    reg [18:0] readyCnt_q;

    wire sclRise = sclS & ~sclP_q;
    wire sclFall = ~sclS & sclP_q;
    wire startC = sclS & sclP_q & sdaP_q & ~sdaS;
    wire stopC = sclS & sclP_q & ~sdaP_q & sdaS;
    wire linkRise = lclkS & ~lclkP_q;
    wire [6:0] primAddr = {`RAR_PRIM_HI, strap_q};
    wire [6:0] busAddr = {`RAR_BUS_HI, strap_q};
    wire bcastOn = nodeSel_q[`RAR_BCAST_BIT];
    wire [7:0] nextByte = {shift_q[6:0], sdaS};

    // Strap pins are caught by a clocked process after reset release, never by the reset itself.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            strap_q <= 2'b00;
            strapDone_q <= 1'b0;
            readyCnt_q <= 19'd0;
            ready <= 1'b0;
        end else begin
            if (!strapDone_q) begin
                strap_q <= addrStrap;
                strapDone_q <= 1'b1;
            end
            if (readyCnt_q >= READY_CYC[18:0] - 19'd1) begin
                ready <= 1'b1;
            end else begin
                readyCnt_q <= readyCnt_q + 19'd1;
            end
        end
    end

    // Software-side view of the node select and the router state.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            swRdata <= 8'h0_000;
        end else if (swRd) begin
            case (swAddr)
                `RAR_SW_NODESEL: swRdata <= nodeSel_q;
                `RAR_SW_STATUS: swRdata <= {4'h0, linkReq, (state_q != ST_IDLE), mstS, ready};
                `RAR_SW_LINKDATA: swRdata <= linkData_q;
                default: swRdata <= 8'h0_000;
            endcase
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sclP_q <= 1'b1;
            sdaP_q <= 1'b1;
            lclkP_q <= 1'b0;
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            shift_q <= 8'h0_000;
            gotReg_q <= 1'b0;
            read_q <= 1'b0;
            remote_q <= 1'b0;
            nack_q <= 1'b0;
            fetchPh_q <= 1'b0;
            issued_q <= 1'b0;
            linkDone_q <= 1'b0;
            dataAck_q <= 1'b0;
            linkData_q <= 8'h0_000;
            nodeSel_q <= `RAR_NODESEL_RST;
            sclOut <= 1'b0;
            sclOeN <= 1'b1;
            sdaOut <= 1'b0;
            sdaOeN <= 1'b1;
            regAddr <= 8'h0_000;
            regWdata <= 8'h0_000;
            regWr <= 1'b0;
            regRd <= 1'b0;
            linkReq <= 1'b0;
            linkWrite <= 1'b0;
            linkNode <= 4'h0;
            linkPeriph <= 1'b0;
            linkBcast <= 1'b0;
            linkAddr <= 8'h0_000;
            linkWdata <= 8'h0_000;
        end else begin
            sclP_q <= sclS;
            sdaP_q <= sdaS;
            lclkP_q <= lclkS;
            regWr <= 1'b0;
            regRd <= 1'b0;
            if (swWr && swAddr == `RAR_SW_NODESEL) begin
                nodeSel_q <= swWdata;
            end
            // Four-phase link handshake, acknowledge sampled on the link clock's rising edge.
            if (linkRise && linkReq && ackS) begin
                linkReq <= 1'b0;
                linkData_q <= linkRdata;
                linkDone_q <= 1'b1;
            end
            if (!ready) begin
                state_q <= ST_IDLE;
            end else if (startC) begin
                state_q <= ST_ADDR;
                cnt_q <= 4'h0;
                sdaOeN <= 1'b1;
            end else if (stopC) begin
                state_q <= ST_IDLE;
                sdaOeN <= 1'b1;
            end else begin
                case (state_q)
                    ST_ADDR: begin
                        if (sclRise) begin
                            shift_q <= nextByte;
                            cnt_q <= cnt_q + 4'h1;
                        end else if (sclFall && cnt_q == `RAR_BYTE_BITS) begin
                            read_q <= shift_q[0];
                            if (shift_q[7:1] == primAddr) begin
                                remote_q <= 1'b0;
                                sdaOeN <= 1'b0;
                                state_q <= ST_ACKA;
                            end else if (shift_q[7:1] == busAddr && mstS) begin
                                remote_q <= 1'b1;
                                sdaOeN <= 1'b0;
                                state_q <= ST_ACKA;
                            end else begin
                                state_q <= ST_IGN;
                            end
                        end
                    end
                    ST_ACKA: begin
                        if (sclFall) begin
                            sdaOeN <= 1'b1;
                            cnt_q <= 4'h0;
                            gotReg_q <= 1'b0;
                            if (read_q) begin
                                sclOeN <= 1'b0;
                                fetchPh_q <= 1'b0;
                                state_q <= ST_FETCH;
                            end else begin
                                state_q <= ST_RX;
                            end
                        end
                    end
                    ST_RX: begin
                        if (sclRise) begin
                            shift_q <= nextByte;
                            cnt_q <= cnt_q + 4'h1;
                        end else if (sclFall && cnt_q == `RAR_BYTE_BITS) begin
                            if (!gotReg_q) begin
                                regAddr <= shift_q;
                                gotReg_q <= 1'b1;
                                dataAck_q <= 1'b0;
                                sdaOeN <= 1'b0;
                                state_q <= ST_ACKW;
                            end else if (remote_q) begin
                                sclOeN <= 1'b0;
                                issued_q <= 1'b0;
                                state_q <= ST_LINKW;
                            end else begin
                                if (regAddr == `RAR_I2C_NODESEL) begin
                                    nodeSel_q <= shift_q;
                                end else begin
                                    regWdata <= shift_q;
                                    regWr <= 1'b1;
                                end
                                sdaOeN <= 1'b0;
                                state_q <= ST_ACKW;
                            end
                        end
                    end
                    ST_LINKW: begin
                        if (!issued_q && !linkReq && !ackS) begin
                            linkReq <= 1'b1;
                            linkWrite <= 1'b1;
                            linkNode <= nodeSel_q[`RAR_NODE_MSB:`RAR_NODE_LSB];
                            linkPeriph <= nodeSel_q[`RAR_PERIPH_BIT];
                            linkBcast <= bcastOn;
                            linkAddr <= regAddr;
                            linkWdata <= shift_q;
                            issued_q <= 1'b1;
                            linkDone_q <= 1'b0;
                        end else if (issued_q && linkDone_q) begin
                            // A broadcast with the peripheral bit clear also lands in the master's own register space.
                            if (bcastOn && !nodeSel_q[`RAR_PERIPH_BIT]) begin
                                regWdata <= linkWdata;
                                regWr <= 1'b1;
                            end
                            linkDone_q <= 1'b0;
                            sdaOeN <= 1'b0;
                            sclOeN <= 1'b1;
                            state_q <= ST_ACKW;
                        end
                    end
                    ST_ACKW: begin
                        if (sclFall) begin
                            sdaOeN <= 1'b1;
                            cnt_q <= 4'h0;
                            // A flag, not a data compare, so a data byte equal to the address still advances.
                            if (dataAck_q) begin
                                regAddr <= regAddr + 8'h0_001;
                            end
                            dataAck_q <= 1'b1;
                            state_q <= ST_RX;
                        end
                    end
                    ST_FETCH: begin
                        // The clock stays held low until the byte is in hand.
                        if (remote_q) begin
                            if (!fetchPh_q && !linkReq && !ackS) begin
                                linkReq <= 1'b1;
                                linkWrite <= 1'b0;
                                linkNode <= nodeSel_q[`RAR_NODE_MSB:`RAR_NODE_LSB];
                                linkPeriph <= nodeSel_q[`RAR_PERIPH_BIT];
                                linkBcast <= 1'b0;
                                linkAddr <= regAddr;
                                fetchPh_q <= 1'b1;
                                linkDone_q <= 1'b0;
                            end else if (fetchPh_q && linkDone_q) begin
                                linkDone_q <= 1'b0;
                                shift_q <= linkData_q;
                                sdaOeN <= linkData_q[7];
                                regAddr <= regAddr + 8'h0_001;
                                sclOeN <= 1'b1;
                                state_q <= ST_TX;
                            end
                        end else if (regAddr == `RAR_I2C_NODESEL) begin
                            shift_q <= nodeSel_q;
                            sdaOeN <= nodeSel_q[7];
                            regAddr <= regAddr + 8'h0_001;
                            sclOeN <= 1'b1;
                            state_q <= ST_TX;
                        end else if (!fetchPh_q) begin
                            regRd <= 1'b1;
                            fetchPh_q <= 1'b1;
                        end else if (!regRd) begin
                            shift_q <= regRdata;
                            sdaOeN <= regRdata[7];
                            regAddr <= regAddr + 8'h0_001;
                            sclOeN <= 1'b1;
                            state_q <= ST_TX;
                        end
                    end
                    ST_TX: begin
                        if (sclRise) begin
                            cnt_q <= cnt_q + 4'h1;
                        end else if (sclFall) begin
                            if (cnt_q == `RAR_BYTE_BITS) begin
                                sdaOeN <= 1'b1;
                                state_q <= ST_MACK;
                            end else begin
                                shift_q <= {shift_q[6:0], 1'b0};
                                sdaOeN <= shift_q[6];
                            end
                        end
                    end
                    ST_MACK: begin
                        if (sclRise) begin
                            nack_q <= sdaS;
                        end else if (sclFall) begin
                            cnt_q <= 4'h0;
                            if (nack_q) begin
                                state_q <= ST_IGN;
                            end else begin
                                sclOeN <= 1'b0;
                                fetchPh_q <= 1'b0;
                                state_q <= ST_FETCH;
                            end
                        end
                    end
                    ST_IGN: begin
                        sdaOeN <= 1'b1;
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

// file: rar_checker.sv
// Port-level checks for the remote access router.
`timescale 1ns/100ps
module rar_checker #(
    parameter READY_CYC = 20
) (
    input wire clk,
    input wire rst,
    input wire sclOeN,
    input wire sdaOeN,
    input wire ready,
    input wire linkReq,
    input wire linkWrite,
    input wire [3:0] linkNode,
    input wire linkPeriph,
    input wire linkBcast,
    input wire [7:0] linkAddr,
    input wire [7:0] linkWdata,
    input wire linkAck
);
    localparam int LIM = READY_CYC + 4;
    int readyCnt_q;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            readyCnt_q <= 0;
        end else if (readyCnt_q < LIM) begin
            readyCnt_q <= readyCnt_q + 1;
        end
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    a_ready_early: assert property (ready |-> readyCnt_q >= READY_CYC - 1)
        else $error("ready rose too early");
    a_ready_late: assert property (readyCnt_q >= LIM |-> ready)
        else $error("ready did not rise in time");
    a_quiet_unready: assert property (!ready |-> sdaOeN && sclOeN)
        else $error("bus driven before ready");
    a_link_stable: assert property (linkReq && $past(linkReq)
        |-> $stable({linkWrite, linkNode, linkPeriph, linkBcast, linkAddr, linkWdata}))
        else $error("link fields moved during request");
    a_link_release: assert property ($fell(linkReq) |-> linkAck)
        else $error("request dropped without acknowledge");
    a_link_fresh: assert property ($rose(linkReq) |-> !linkAck)
        else $error("request raised while acknowledge high");
    a_read_stretch: assert property (linkReq && !linkWrite |-> !sclOeN)
        else $error("bus clock not held during remote read");
    a_read_unicast: assert property (linkReq && !linkWrite |-> !linkBcast)
        else $error("remote read marked broadcast");
    a_stretch_end: assert property ($fell(linkReq) |-> ##[0:64] sclOeN)
        else $error("bus clock not released after answer");
endmodule
bind rar_router rar_checker #(.READY_CYC(READY_CYC)) i_chk (.clk(clk), .rst(rst), .sclOeN(sclOeN),
    .sdaOeN(sdaOeN), .ready(ready), .linkReq(linkReq), .linkWrite(linkWrite), .linkNode(linkNode),
    .linkPeriph(linkPeriph), .linkBcast(linkBcast), .linkAddr(linkAddr), .linkWdata(linkWdata), .linkAck(linkAck));

// file: rar_host_model.sv
// Two-wire bus controller model that issues transfers to the router.
`timescale 1ns/100ps
module rar_host_model #(
    parameter Q = 8
) (
    input wire clk,
    input wire scl,
    input wire sda,
    output reg sclOeN,
    output reg sdaOeN
);
    initial begin
        sclOeN = 1'b1;
        sdaOeN = 1'b1;
    end
    task automatic qtr;
        repeat (Q) @(posedge clk);
    endtask
    // The router may hold the clock low, so wait on the line rather than on our own release.
    task automatic sclUp;
        int k;
        sclOeN <= 1'b1;
        for (k = 0; k < 4000 && scl !== 1'b1; k++) @(posedge clk);
    endtask
    task automatic xbit(input logic b, output logic r);
        sdaOeN <= b;
        qtr;
        sclUp;
        qtr;
        r = sda;
        qtr;
        sclOeN <= 1'b0;
        qtr;
    endtask
    task automatic start;
        sdaOeN <= 1'b1;
        qtr;
        sclUp;
        qtr;
        sdaOeN <= 1'b0;
        qtr;
        sclOeN <= 1'b0;
        qtr;
    endtask
    task automatic stop;
        sdaOeN <= 1'b0;
        qtr;
        sclUp;
        qtr;
        sdaOeN <= 1'b1;
        qtr;
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        int i;
        logic r;
        for (i = 7; i >= 0; i--) xbit(d[i], r);
        xbit(1'b1, ack);
    endtask
    task automatic rbyte(input logic last, output logic [7:0] d);
        int i;
        logic r;
        for (i = 7; i >= 0; i--) xbit(1'b1, d[i]);
        xbit(last, r);
    endtask
endmodule

// file: tb_rar_router.sv
// Self-checking bench for the two-wire remote access router.
`timescale 1ns/100ps
module tb_rar_router;
    localparam int RDY = 20;
    localparam logic [6:0] PRIM = 7'h69;
    localparam logic [6:0] BUS = 7'h6D;
    localparam logic [7:0] LRD = 8'hC3;
    typedef struct {logic [6:0] dev; logic [7:0] ra, wd; logic loc, lnk; logic [7:0] sel;} rar_row_t;
    logic clk = 1'b0, rst = 1'b1, masterMode = 1'b1, swWr = 1'b0, swRd = 1'b0, linkClk = 1'b0, linkAck = 1'b0;
    logic [3:0] swAddr = 4'h0;
    logic [7:0] swWdata = 8'h00, regRdata = 8'h00, linkRdata = 8'h00;
    wire sclOut, sclOeN, sdaOut, sdaOeN, ready, regWr, regRd, linkReq, linkWrite, linkPeriph, linkBcast, hScl, hSda;
    wire [7:0] regAddr, regWdata, swRdata, linkAddr, linkWdata;
    wire [3:0] linkNode;
    wire sclLine = (sclOeN | sclOut) & hScl;
    wire sdaLine = (sdaOeN | sdaOut) & hSda;
    int n_fail = 0, cmp_count = 0, cyc = 0, nLoc = 0, nLnk = 0, ackDly = 3, ackWait = 0, k, j;
    logic [7:0] lastRa, lastWd, lkAddr, lkWd, lkSel, d;
    logic lkWr, reqQ = 1'b0, ack;
    rar_row_t rows [11];
    rar_router #(.READY_CYC(RDY)) i_dut (.clk(clk), .rst(rst), .sclIn(sclLine), .sclOut(sclOut), .sclOeN(sclOeN),
        .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .masterMode(masterMode), .addrStrap(2'b01),
        .ready(ready), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .swAddr(swAddr), .swWdata(swWdata), .swWr(swWr), .swRd(swRd), .swRdata(swRdata), .linkClk(linkClk),
        .linkReq(linkReq), .linkWrite(linkWrite), .linkNode(linkNode), .linkPeriph(linkPeriph), .linkBcast(linkBcast),
        .linkAddr(linkAddr), .linkWdata(linkWdata), .linkAck(linkAck), .linkRdata(linkRdata));
    rar_host_model #(.Q(8)) i_host (.clk(clk), .scl(sclLine), .sda(sdaLine), .sclOeN(hScl), .sdaOeN(hSda));
    initial begin
        forever #4 clk = ~clk;
    end
    initial begin
        #3;
        forever #32 linkClk = ~linkClk;
    end
    always @(posedge clk) begin
        regRdata <= regRd ? regAddr ^ 8'hA5 : ~regRdata;
        if (regWr) begin
            nLoc++;
            lastRa = regAddr;
            lastWd = regWdata;
        end
        if (linkReq && !reqQ) begin
            nLnk++;
            {lkWr, lkAddr, lkWd} = {linkWrite, linkAddr, linkWdata};
            lkSel = {linkBcast, 1'b0, linkPeriph, 1'b0, linkNode};
        end
        reqQ = linkReq;
        // Released data toggles every cycle so a late capture cannot match by luck.
        if (!linkReq) begin
            linkAck <= 1'b0;
            ackWait = 0;
            linkRdata <= ~linkRdata;
        end else if (ackWait < ackDly) begin
            ackWait++;
        end else begin
            linkAck <= 1'b1;
            linkRdata <= LRD;
        end
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            complete_run;
        end
    end
    task automatic check(input string what, input logic [63:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic swAcc(input logic wr, input logic [3:0] a, input logic [7:0] wd, output logic [7:0] rd);
        @(posedge clk);
        swAddr <= a;
        swWdata <= wd;
        swWr <= wr;
        swRd <= !wr;
        @(posedge clk);
        swWr <= 1'b0;
        swRd <= 1'b0;
        @(negedge clk);
        rd = swRdata;
    endtask
    task automatic put(input logic [7:0] b, input logic expAck);
        i_host.wbyte(b, ack);
        check("ack", ack, expAck);
    endtask
    task automatic xfer(input logic [6:0] dev, input logic [7:0] ra, wd, input logic rd);
        @(posedge clk);
        i_host.start;
        put({dev, 1'b0}, 1'b0);
        put(ra, 1'b0);
        if (rd) begin
            i_host.start;
            put({dev, 1'b1}, 1'b0);
            i_host.rbyte(1'b1, d);
        end else begin
            put(wd, 1'b0);
        end
        i_host.stop;
    endtask
    initial begin
        rows = '{'{PRIM, 8'h10, 8'h5A, 1'b1, 1'b0, 8'h00},
            '{PRIM, 8'h01, 8'h01, 1'b0, 1'b0, 8'h00},
            '{BUS, 8'h22, 8'h33, 1'b0, 1'b1, 8'h01},
            '{PRIM, 8'h01, 8'h00, 1'b0, 1'b0, 8'h00},
            '{BUS, 8'h23, 8'h34, 1'b0, 1'b1, 8'h00},
            '{PRIM, 8'h01, 8'h21, 1'b0, 1'b0, 8'h00},
            '{BUS, 8'h40, 8'h77, 1'b0, 1'b1, 8'h21},
            '{PRIM, 8'h01, 8'h80, 1'b0, 1'b0, 8'h00},
            '{BUS, 8'h05, 8'h66, 1'b1, 1'b1, 8'h80},
            '{PRIM, 8'h01, 8'hA1, 1'b0, 1'b0, 8'h00},
            '{BUS, 8'h06, 8'h67, 1'b0, 1'b1, 8'hA1}};
        repeat (3) @(posedge clk);
        check("reset state", {sclOeN, sdaOeN, ready, linkReq, swRdata}, 12'hC00);
        rst <= 1'b0;
        k = 0;
        while (ready !== 1'b1 && k < 200) begin
            @(posedge clk);
            k++;
        end
        check("ready time", k inside {[RDY:RDY + 3]}, 1'b1);
        swAcc(1'b1, 4'h0, 8'h21, d);
        swAcc(1'b0, 4'h0, 8'h00, d);
        check("sw select", d, 8'h21);
        swAcc(1'b0, 4'h1, 8'h00, d);
        check("sw status", d & 8'h03, 8'h03);
        swAcc(1'b0, 4'h5, 8'h00, d);
        check("sw unmapped", d, 8'h00);
        $display("register port test done");
        foreach (rows[i]) begin
            k = nLoc;
            j = nLnk;
            xfer(rows[i].dev, rows[i].ra, rows[i].wd, 1'b0);
            check("local write", nLoc - k, rows[i].loc);
            check("link request", nLnk - j, rows[i].lnk);
            if (rows[i].loc) check("local data", {lastRa, lastWd}, {rows[i].ra, rows[i].wd});
            if (rows[i].lnk) check("link fields", {lkWr, lkSel, lkAddr, lkWd}, {1'b1, rows[i].sel, rows[i].ra, rows[i].wd});
            $display("row %0d done", i);
        end
        // A slow far side must keep the bus clock held until the byte is back.
        ackDly = 300;
        xfer(PRIM, 8'h01, 8'h01, 1'b0);
        xfer(BUS, 8'h30, 8'h00, 1'b1);
        check("remote read", {d, lkWr, lkAddr, lkSel}, {LRD, 1'b0, 8'h30, 8'h01});
        swAcc(1'b0, 4'h2, 8'h00, d);
        check("link read data", d, LRD);
        ackDly = 3;
        xfer(PRIM, 8'h10, 8'h00, 1'b1);
        check("direct read", d, 8'hB5);
        $display("read test done");
        k = nLoc;
        @(posedge clk);
        i_host.start;
        put(8'h20, 1'b1);
        i_host.stop;
        masterMode <= 1'b0;
        repeat (5) @(posedge clk);
        i_host.start;
        put({BUS, 1'b0}, 1'b1);
        i_host.stop;
        xfer(PRIM, 8'h12, 8'h44, 1'b0);
        check("slave direct", {nLoc - k, lastRa, lastWd}, {32'h0000_0001, 8'h12, 8'h44});
        $display("address decode test done");
        complete_run;
    end
endmodule
